/* File: logic/seq_pkg.sv */
/*
 * Shared constants, types and the duration conversion for the program
 * setpoint sequencer. Assumes a single 200 MHz clock domain.
 */
`default_nettype none

package seq_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int SEC_NS = 1_000_000_000;
    localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
    localparam logic [5:0] SEC_PER_MIN = 6'h3C;
    localparam logic [3:0] HOLDOFF_MAX_S = 4'hA;
    localparam logic [3:0] HOLDOFF_RST = 4'h0;

    // Register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_HOLDOFF = 8'h04;
    localparam logic [7:0] OFS_SEG_INDEX = 8'h08;
    localparam logic [7:0] OFS_SEG_GOAL = 8'h0C;
    localparam logic [7:0] OFS_SEG_VALUE = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_SETPOINT = 8'h18;

    // Field positions
    localparam int CTRL_METHOD_BIT = 0;
    localparam int CTRL_UNIT_BIT = 1;
    localparam int CTRL_RESTART_BIT = 2;
    localparam int VAL_MAJOR_LSB = 8;
    localparam int VAL_RAW_BIT = 18;

    // Encodings and ranges (setpoint in 0.1 % of span)
    localparam logic METHOD_TIME = 1'b0;
    localparam logic METHOD_RATE = 1'b1;
    localparam logic UNIT_HM = 1'b0;
    localparam logic UNIT_MS = 1'b1;
    localparam logic [15:0] SPAN = 16'h03E8;
    localparam logic [7:0] MINOR_MAX = 8'h3B;
    localparam logic [15:0] PER_MAJOR = 16'h003C;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        S_HOLD = 3'b000,
        S_LOAD = 3'b001,
        S_DIV = 3'b010,
        S_RUN = 3'b011,
        S_SKIP = 3'b100,
        S_DONE = 3'b101
    } seq_state_t;

    typedef enum logic [1:0] {
        K_TIME = 2'b00,
        K_SOAK = 2'b01,
        K_RAMP = 2'b10
    } seg_kind_t;

    // major.minor to base ticks, minor held to 00..59
    function automatic logic [15:0] to_base(input logic [9:0] major, input logic [7:0] minor);
        logic [7:0] mn;
        mn = (minor > MINOR_MAX) ? MINOR_MAX : minor;
        return 16'(major * PER_MAJOR) + {8'h00, mn};
    endfunction
endpackage

`default_nettype wire

/* File: logic/setpoint_sequencer.sv */
/*
 * Program setpoint sequencer: holdoff stage left at once (holdoff_q resets to 0), segment memory written over
 * a plain register port, and a per-segment engine producing the setpoint.
 * Assumes ctrl_tick_i is a one-cycle control-period pulse from clk_i logic
 * and that register strobes are synchronous one-cycle pulses.
 */
// Added by the designer: the placing of the registers and the strobed register port.
`default_nettype none

// Behaviour
// RQ1: Hold off start for 0..10 s after reset; holdoff_q resets to 0, so the engine leaves S_HOLD on the first clock
// RQ2: One method setting interprets all patterns
// RQ3: Method change clears every stored segment
// RQ4: Duration mode reaches goal exactly at end
// RQ5: Zero duration advances after one control period
// RQ6: Raw link values taken as base units
// RQ7: Rate is span change per hour/minute
// RQ8: Equal goal in rate mode soaks
// RQ9: Higher goal ramps up at rate
// RQ10: Lower goal ramps down at rate
// RQ11: Zero rate or soak advances after one period
// RQ12: One time unit governs all times
// RQ13: Unit hour.minute or minute.second selects rate base
// RQ14: major.minor becomes major*60+minor, minor max 59
// RQ15: Unregistered segment ends the pattern
module setpoint_sequencer
    import seq_pkg::*;
#(
    parameter int NSEG = 16,
    parameter int CYCLES_PER_SEC = SEC_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Control period
    input wire logic ctrl_tick_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [31:0] reg_rdata_o,
    // Program output
    output logic [15:0] setpoint_o,
    output logic running_o,
    output logic holdoff_done_o
);
    localparam int IW = $clog2(NSEG) + 1;

    logic [31:0] ctrl_q;
    logic [3:0] holdoff_q;
    logic [IW-1:0] wr_idx_q;
    logic [15:0] goal_mem [NSEG];
    logic [18:0] val_mem [NSEG];
    logic [NSEG-1:0] valid_q;
    logic [31:0] presc_q;
    logic [5:0] sec_cnt_q;
    logic [3:0] hold_cnt_q;
    logic sec_pulse, min_pulse, base_tick;
    seq_state_t state_q;
    seg_kind_t kind_q;
    logic [IW-1:0] seg_q;
    logic [31:0] sp_fx_q, step_q;
    logic [15:0] goal_q, prev_goal_q, dur_q, elapsed_q;
    logic down_q;
    logic [16:0] rem_q;
    logic [15:0] dvs_q;
    logic [5:0] div_cnt_q;

    wire logic wr_ctrl = reg_we_i && reg_addr_i == OFS_CTRL;
    wire logic method = ctrl_q[CTRL_METHOD_BIT];
    wire logic unit = ctrl_q[CTRL_UNIT_BIT];
    wire logic method_flip = wr_ctrl && reg_wdata_i[CTRL_METHOD_BIT] != method;
    wire logic restart = wr_ctrl && reg_wdata_i[CTRL_RESTART_BIT];
    wire logic [IW-2:0] wr_slot = wr_idx_q[IW-2:0];
    wire logic [IW-2:0] rd_slot = seg_q[IW-2:0];
    wire logic [18:0] cur_val = val_mem[rd_slot];
    wire logic [15:0] cur_goal = goal_mem[rd_slot];
    wire logic [15:0] cur_ticks = cur_val[VAL_RAW_BIT] ? cur_val[15:0]
        : to_base(cur_val[17:VAL_MAJOR_LSB], cur_val[7:0]);
    wire logic [15:0] cur_rate = (cur_val[15:0] > SPAN) ? SPAN : cur_val[15:0];
    wire logic [15:0] sp_int = sp_fx_q[31:16];
    wire logic [31:0] goal_fx = {goal_q, 16'h0000};
    wire logic [16:0] rem_sh = {rem_q[15:0], step_q[31]};
    wire logic seg_end = seg_q == IW'(NSEG) || !valid_q[rd_slot];

    // Control, holdoff and the segment memory
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_q <= CTRL_RST;
            holdoff_q <= HOLDOFF_RST;
            wr_idx_q <= '0;
            valid_q <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= {30'h0, reg_wdata_i[CTRL_UNIT_BIT], reg_wdata_i[CTRL_METHOD_BIT]};
            end
            if (reg_we_i && reg_addr_i == OFS_HOLDOFF) begin
                holdoff_q <= (reg_wdata_i[3:0] > HOLDOFF_MAX_S) ? HOLDOFF_MAX_S
                    : reg_wdata_i[3:0];
            end
            if (reg_we_i && reg_addr_i == OFS_SEG_INDEX) begin
                wr_idx_q <= {1'b0, reg_wdata_i[IW-2:0]};
            end
            if (method_flip) begin
                valid_q <= '0; // [RQ3]
            end else if (reg_we_i && reg_addr_i == OFS_SEG_VALUE) begin
                valid_q[wr_slot] <= 1'b1;
            end
        end
    end

    // Pattern storage; a value write registers the slot
    always_ff @(posedge clk_i) begin
        if (reg_we_i && reg_addr_i == OFS_SEG_GOAL) begin
            goal_mem[wr_slot] <= (reg_wdata_i[15:0] > SPAN) ? SPAN : reg_wdata_i[15:0];
        end
        if (reg_we_i && reg_addr_i == OFS_SEG_VALUE && !method_flip) begin
            val_mem[wr_slot] <= reg_wdata_i[18:0]; // [RQ6]
        end
    end

    // Time base: seconds, minutes, and the unit-selected base tick
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            presc_q <= '0;
            sec_cnt_q <= '0;
        end else begin
            presc_q <= sec_pulse ? '0 : presc_q + 32'h1;
            if (sec_pulse) begin
                sec_cnt_q <= min_pulse ? '0 : sec_cnt_q + 6'h1;
            end
        end
    end
    assign sec_pulse = presc_q == 32'(CYCLES_PER_SEC - 1);
    assign min_pulse = sec_pulse && sec_cnt_q == SEC_PER_MIN - 6'h1;
    // Minutes for hour.minute, seconds for minute.second
    assign base_tick = (unit == UNIT_MS) ? sec_pulse : min_pulse; // [RQ12] [RQ13]

    // Power-on holdoff counter; zero lets the engine start at once
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hold_cnt_q <= '0;
        end else if (state_q != S_HOLD) begin
            // Spent once the engine runs, so a later holdoff write cannot stall it
            hold_cnt_q <= HOLDOFF_MAX_S;
        end else if (sec_pulse && hold_cnt_q < holdoff_q) begin
            hold_cnt_q <= hold_cnt_q + 4'h1; // [RQ1]
        end
    end

    // Segment engine
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= S_HOLD;
            kind_q <= K_TIME;
            seg_q <= '0;
            sp_fx_q <= '0;
            step_q <= '0;
            goal_q <= '0;
            prev_goal_q <= '0;
            dur_q <= '0;
            elapsed_q <= '0;
            down_q <= 1'b0;
            rem_q <= '0;
            dvs_q <= '0;
            div_cnt_q <= '0;
        end else if (method_flip && state_q != S_HOLD) begin
            state_q <= S_DONE;
        end else if (restart && state_q != S_HOLD) begin
            seg_q <= '0;
            prev_goal_q <= sp_int;
            // Drop the fraction so a first soak holds exactly
            sp_fx_q[15:0] <= '0;
            state_q <= S_LOAD;
        end else begin
            case (state_q)
                S_HOLD: begin
                    if (hold_cnt_q >= holdoff_q) begin
                        state_q <= S_LOAD; // [RQ1]
                    end
                end
                S_LOAD: begin
                    goal_q <= cur_goal;
                    elapsed_q <= '0;
                    rem_q <= '0;
                    div_cnt_q <= '0;
                    if (seg_end) begin
                        state_q <= S_DONE; // [RQ15]
                    end else if (method == METHOD_TIME) begin // [RQ2]
                        kind_q <= K_TIME;
                        dur_q <= cur_ticks; // [RQ14]
                        down_q <= cur_goal < sp_int;
                        sp_fx_q[15:0] <= '0;
                        // Dividend shares the quotient register's role in the divider
                        step_q <= {(cur_goal < sp_int) ? sp_int - cur_goal
                            : cur_goal - sp_int, 16'h0000};
                        dvs_q <= cur_ticks;
                        state_q <= (cur_ticks == '0) ? S_SKIP : S_DIV; // [RQ5] [RQ4]
                    end else if (cur_goal == prev_goal_q) begin
                        kind_q <= K_SOAK; // [RQ8]
                        dur_q <= cur_ticks;
                        state_q <= (cur_ticks == '0) ? S_SKIP : S_RUN; // [RQ11]
                    end else begin
                        kind_q <= K_RAMP;
                        down_q <= cur_goal < prev_goal_q; // [RQ9] [RQ10]
                        // Rounded up so truncation never costs an extra base tick
                        step_q <= {cur_rate, 16'h0000} + 32'(PER_MAJOR - 16'h1); // [RQ7]
                        dvs_q <= PER_MAJOR;
                        state_q <= (cur_rate == '0) ? S_SKIP : S_DIV; // [RQ11]
                    end
                end
                S_DIV: begin
                    // Restoring divide, 32 steps; avoids a combinational divider
                    div_cnt_q <= div_cnt_q + 6'h1;
                    if (rem_sh >= {1'b0, dvs_q}) begin
                        rem_q <= rem_sh - {1'b0, dvs_q};
                        step_q <= {step_q[30:0], 1'b1};
                    end else begin
                        rem_q <= rem_sh;
                        step_q <= {step_q[30:0], 1'b0};
                    end
                    if (div_cnt_q == 6'h1F) begin
                        state_q <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (base_tick) begin
                        elapsed_q <= elapsed_q + 16'h1;
                        case (kind_q)
                            K_TIME, K_SOAK: begin
                                if (elapsed_q + 16'h1 >= dur_q) begin
                                    sp_fx_q <= goal_fx; // [RQ4] [RQ8]
                                    prev_goal_q <= goal_q;
                                    seg_q <= seg_q + IW'(1);
                                    state_q <= S_LOAD;
                                end else if (kind_q == K_TIME) begin
                                    sp_fx_q <= down_q ? sp_fx_q - step_q : sp_fx_q + step_q;
                                end
                            end
                            K_RAMP: begin
                                if ((down_q && sp_fx_q - goal_fx <= step_q)
                                    || (!down_q && goal_fx - sp_fx_q <= step_q)) begin
                                    sp_fx_q <= goal_fx;
                                    prev_goal_q <= goal_q;
                                    seg_q <= seg_q + IW'(1);
                                    state_q <= S_LOAD;
                                end else begin
                                    // [RQ9] [RQ10]
                                    sp_fx_q <= down_q ? sp_fx_q - step_q : sp_fx_q + step_q;
                                end
                            end
                            default: state_q <= S_DONE;
                        endcase
                    end
                end
                S_SKIP: begin
                    if (ctrl_tick_i) begin
                        sp_fx_q <= goal_fx; // [RQ5] [RQ11]
                        prev_goal_q <= goal_q;
                        seg_q <= seg_q + IW'(1);
                        state_q <= S_LOAD;
                    end
                end
                S_DONE: state_q <= S_DONE;
                default: state_q <= S_DONE;
            endcase
        end
    end

    // Register read, one cycle after the strobe
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= '0;
        end else if (reg_re_i) begin
            case (reg_addr_i)
                OFS_CTRL: reg_rdata_o <= ctrl_q;
                OFS_HOLDOFF: reg_rdata_o <= {28'h0, holdoff_q};
                OFS_SEG_INDEX: reg_rdata_o <= 32'(wr_idx_q);
                OFS_STATUS: reg_rdata_o <= {16'h0, 8'(seg_q), 5'h0, state_q};
                OFS_SETPOINT: reg_rdata_o <= {16'h0, sp_int};
                default: reg_rdata_o <= '0;
            endcase
        end else begin
            reg_rdata_o <= '0;
        end
    end

    assign setpoint_o = sp_int;
    assign running_o = state_q != S_HOLD && state_q != S_DONE;
    assign holdoff_done_o = state_q != S_HOLD;

    // Checks
    sequence seq_skip_taken;
        state_q == S_SKIP && ctrl_tick_i && !method_flip && !restart;
    endsequence
    sequence seq_at_goal_reload;
        state_q == S_LOAD && sp_int == $past(goal_q);
    endsequence

    AST_HOLDOFF: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ1]
        hold_cnt_q < holdoff_q |-> state_q == S_HOLD)
        else $error("engine left holdoff early");
    AST_METHOD_CLEAR: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ3]
        method_flip |=> valid_q == '0 && ctrl_q[CTRL_METHOD_BIT] != $past(method))
        else $error("method change kept segments");
    AST_ZERO_ADVANCE: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ5]
        seq_skip_taken |=> seq_at_goal_reload)
        else $error("zero segment did not advance to goal");
    AST_TIME_END: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ4]
        state_q == S_RUN && kind_q == K_TIME && base_tick && !method_flip && !restart
        && elapsed_q + 16'h1 == dur_q |=> sp_int == $past(goal_q) && state_q == S_LOAD)
        else $error("segment end missed goal");
    AST_UNREG_END: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ15]
        state_q == S_LOAD && seg_end && !method_flip && !restart |=> state_q == S_DONE)
        else $error("unregistered segment executed");
    AST_SOAK_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ8]
        state_q == S_RUN && kind_q == K_SOAK |=> sp_fx_q == $past(sp_fx_q))
        else $error("soak moved the setpoint");
    AST_RAMP_UP: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ9]
        state_q == S_RUN && kind_q == K_RAMP && !down_q && !method_flip && !restart
        |=> sp_fx_q >= $past(sp_fx_q) && sp_int <= $past(goal_q))
        else $error("upward ramp fell or overshot");
    AST_RAMP_DOWN: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ10]
        state_q == S_RUN && kind_q == K_RAMP && down_q && !method_flip && !restart
        |=> sp_fx_q <= $past(sp_fx_q) && sp_int >= $past(goal_q))
        else $error("downward ramp rose or undershot");
    AST_RATE_ZERO: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ11]
        state_q == S_LOAD && !seg_end && method == METHOD_RATE && !method_flip && !restart
        && cur_goal != prev_goal_q && cur_rate == '0 |=> state_q == S_SKIP)
        else $error("zero rate did not skip");
    AST_RAMP_END: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ9]
        state_q == S_RUN && kind_q == K_RAMP && base_tick && !method_flip && !restart
        && (down_q ? sp_fx_q - goal_fx : goal_fx - sp_fx_q) <= step_q
        |=> sp_int == $past(goal_q) && state_q == S_LOAD)
        else $error("ramp did not finish on goal");
    AST_STEP_NONZERO: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ7]
        state_q == S_DIV && div_cnt_q == 6'h1F && kind_q == K_RAMP && !method_flip && !restart
        |=> state_q == S_RUN && step_q != 32'h0)
        else $error("nonzero rate gave a zero step");
    AST_METHOD_KIND: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ2]
        state_q == S_LOAD && !seg_end && method == METHOD_TIME && !method_flip && !restart
        |=> kind_q == K_TIME)
        else $error("duration method ran another segment kind");
endmodule // setpoint_sequencer

`default_nettype wire

/* File: bench/setpoint_sequencer_tb_top.sv */
/*
 * Self-checking bench for the program setpoint sequencer: register port
 * traffic, duration and rate programs, unit change, method-change clear.
 * Assumes the design's assertions live in the design files; one clock.
 */
`default_nettype none

module setpoint_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import seq_pkg::*;

    // Short second keeps long segments affordable
    localparam int CPS = 50;
    localparam int LIMIT = 45000;

    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic ctrl_tick_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic reg_we_i = 1'b0;
    logic reg_re_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic [15:0] setpoint_o;
    logic running_o;
    logic holdoff_done_o;
    logic rd_pend = 1'b0;
    logic [31:0] exp_q[$];
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int tick_cnt = 0;
    logic [15:0] g;

    setpoint_sequencer #(.NSEG(16), .CYCLES_PER_SEC(CPS)) setpoint_sequencer_inst (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ctrl_tick_i(ctrl_tick_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
        .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .setpoint_o(setpoint_o),
        .running_o(running_o), .holdoff_done_o(holdoff_done_o));

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    // Control period of seven clocks
    always @(posedge clk_i) begin
        tick_cnt <= (tick_cnt == 6) ? 0 : tick_cnt + 1;
        ctrl_tick_i <= (tick_cnt == 6);
        rd_pend <= reg_re_i;
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Read data stand only in the cycle after the strobe
    always @(negedge clk_i) begin
        if (rd_pend) begin
            if (exp_q.size() == 0) check(reg_rdata_o, 32'hFFFF_FFFF);
            else check(reg_rdata_o, exp_q.pop_front());
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_i);
        reg_re_i <= 1'b0;
    endtask

    task automatic wseg(input int idx, input logic [15:0] goal, input logic [31:0] v);
        wr(OFS_SEG_INDEX, 32'(idx));
        wr(OFS_SEG_GOAL, {16'h0000, goal});
        wr(OFS_SEG_VALUE, v);
    endtask

    // Restart and time the program until the engine stops
    task automatic run_prog(input logic [1:0] ctl, input int lo, input int hi,
                            input logic [15:0] fin);
        int n;
        n = 0;
        wr(OFS_CTRL, {29'h0, 1'b1, ctl});
        #1;
        while (running_o === 1'b1 && n < LIMIT) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check({31'h0, (n >= lo && n <= hi)}, 32'h0000_0001);
        check({16'h0000, setpoint_o}, {16'h0000, fin});
        rd(OFS_SETPOINT, {16'h0000, fin});
        rd(OFS_CTRL, {30'h0, ctl});
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        void'($urandom(48));
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        // Reset values, clamp, unmapped place
        rd(OFS_CTRL, CTRL_RST);
        rd(OFS_HOLDOFF, {28'h0, HOLDOFF_RST});
        rd(8'hFC, 32'h0000_0000);
        wr(OFS_HOLDOFF, 32'h0000_000C);
        rd(OFS_HOLDOFF, {28'h0, HOLDOFF_MAX_S});
        check({31'h0, holdoff_done_o}, 32'h0000_0001);
        wr(OFS_HOLDOFF, 32'h0000_0000);
        $display("test registers done");
        // Duration program: random goal, clamped minor, zero segment, gap
        g = 16'($urandom_range(1000));
        wr(OFS_CTRL, {30'h0, UNIT_MS, METHOD_TIME});
        wseg(0, g, 32'h0000_0002);
        wseg(1, 16'h01F4, 32'h0000_003F);
        wseg(2, 16'h00FA, 32'h0000_0000);
        wseg(4, 16'h0384, 32'h0000_0001);
        run_prog({UNIT_MS, METHOD_TIME}, 60 * CPS, 61 * CPS + 150, 16'h00FA);
        $display("test duration done");
        // Method change drops every stored segment
        wr(OFS_CTRL, {30'h0, UNIT_MS, METHOD_RATE});
        run_prog({UNIT_MS, METHOD_RATE}, 0, 4, 16'h00FA);
        rd(OFS_STATUS, {16'h0000, 8'h00, 5'h00, S_DONE});
        $display("test clear done");
        // Ramp per hour: 100 at 1000 per hour is six minute ticks
        wr(OFS_CTRL, {30'h0, UNIT_HM, METHOD_RATE});
        wseg(0, 16'h015E, 32'h0000_03E8);
        run_prog({UNIT_HM, METHOD_RATE}, 5 * 60 * CPS, 6 * 60 * CPS + 200, 16'h015E);
        $display("test hour unit done");
        // Soak, ramp up, ramp down, zero rate, zero soak per minute
        wr(OFS_CTRL, {30'h0, UNIT_MS, METHOD_RATE});
        // Raw soak of 80 s; decoded it would clamp to 59
        wseg(0, 16'h015E, 32'h0004_0050);
        wseg(1, 16'h0226, 32'h0000_0064);
        wseg(2, 16'h01C2, 32'h0000_00C8);
        wseg(3, 16'h0320, 32'h0000_0000);
        wseg(4, 16'h0320, 32'h0000_0000);
        rd(OFS_SEG_INDEX, 32'h0000_0004);
        run_prog({UNIT_MS, METHOD_RATE}, 229 * CPS, 230 * CPS + 100, 16'h0320);
        rd(OFS_STATUS, {16'h0000, 8'h05, 5'h00, S_DONE});
        $display("test rate done");
        repeat (3) @(posedge clk_i);
        give_verdict();
    end
endmodule // setpoint_sequencer_tb_top

`default_nettype wire
